// ===== verilog/iwps_pkg.sv
// Shared constants, register map and state encodings for the wiper position link
package iwps_pkg;

  // Clock and timing
  localparam int CLK_NS    = 10;
  localparam int PWRUP_NS  = 1000;  // Start conditions ignored this long after reset
  localparam int BO_NS     = 200;   // Least brownout dip that counts
  localparam int SCL_Q_NS  = 700;   // One quarter of a host bus clock period
  localparam logic [7:0] PWRUP_CYC = 8'((PWRUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] BO_CYC    = 8'((BO_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] SCL_Q_CYC = 8'((SCL_Q_NS + CLK_NS - 1) / CLK_NS);

  // Identification byte and device register map
  localparam logic [4:0] ID_FIXED   = 5'h14;  // 10100
  localparam logic [7:0] REG_WIPER  = 8'h00;
  localparam logic [7:0] REG_ACR    = 8'h10;
  localparam int         WIPER_W    = 7;
  localparam logic [6:0] WIPER_RST  = 7'h40;
  localparam int         POWER_DOWN_CTL_BIT   = 6;
  localparam logic       POWER_DOWN_CTL_RST   = 1'h1;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] LAST_TX    = 4'h7;

  // Host register map on APB
  localparam logic [7:0] HR_CTRL    = 8'h00;
  localparam logic [7:0] HR_TARGET  = 8'h04;
  localparam logic [7:0] HR_WDATA   = 8'h08;
  localparam logic [7:0] HR_STATUS  = 8'h0C;
  localparam logic [7:0] HR_RDATA   = 8'h10;
  localparam int CTRL_GO   = 0;
  localparam int CTRL_READ = 1;
  localparam int CTRL_LEN  = 2;   // Two bits: bytes read minus one
  localparam int TGT_RADDR = 8;   // Register address field [15:8]
  localparam int ST_BUSY   = 0;
  localparam int ST_NACK   = 1;

  // Host sequence steps
  localparam logic [2:0] STEP_IDW  = 3'h0;
  localparam logic [2:0] STEP_REG  = 3'h1;
  localparam logic [2:0] STEP_DATA = 3'h2;
  localparam logic [2:0] STEP_IDR  = 3'h3;
  localparam logic [2:0] STEP_RX   = 3'h4;

  typedef enum logic [4:0] {
    D_IDLE = 5'h01,
    D_RX   = 5'h02,
    D_ACK  = 5'h04,
    D_TX   = 5'h08,
    D_MACK = 5'h10
  } iwps_dstate_t;

  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_START = 4'h2,
    H_BIT   = 4'h4,
    H_STOP  = 4'h8
  } iwps_hstate_t;

endpackage

// ===== verilog/iwps_if.sv
// Two-wire bus between the host controller and the wiper device
interface iwps_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Open-drain data line with pull-up: low when any enabled driver drives low
  assign sda = !((host_sda_oe & !host_sda_o) | (dev_sda_oe & !dev_sda_o));

  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
endinterface

// ===== verilog/iwps_device.sv
// Wiper position device: bus slave front end, wiper and access control registers

// Overview of operation
// - code 127 nearest high, 0 nearest low
// - sample on rise, drive after fall
// - straps give two address LSBs, must match
// - seven-bit wiper, codes 00h to 7Fh
// - wiper loads 40h at power-up
// - address 0 wiper, 10h access control
// - bit 6 low means shutdown, resets high
// - shutdown keeps stored wiper position
// - brownout in shutdown resets wiper mid
// - every byte goes MSB first
// - data pin input, START ignored during power-up
// - nothing happens before a START
// - STOP returns device to standby
// - sender releases, receiver acknowledges ninth clock
// - identity 10100, straps, then direction bit
// - acknowledge identity, address, write data
// - master acknowledges read bytes except last
// - write is id, address, data; update ninth clock
// - read uses repeated START then read id
// - master ends read with NACK, STOP
// - data changes only while clock low
module iwps_device
  import iwps_pkg::*;
(
  iwps_if.device                      bus,
  input  logic                        pclk,
  input  logic                        presetn,
  input  logic                        address_strap_upper,
  input  logic                        address_strap_lower,
  input  logic                        brownout,
  output logic [iwps_pkg::WIPER_W-1:0] wiper_pos,
  output logic                        power_down_ctl
);
  import iwps_pkg::*;

  typedef struct packed {
    iwps_dstate_t st;
    logic         scl_m;
    logic         scl_s;
    logic         scl_p;
    logic         sda_m;
    logic         sda_s;
    logic         sda_p;
    logic [1:0]   strap_m;
    logic [1:0]   strap_s;
    logic         bo_m;
    logic         bo_s;
    logic [7:0]   pu_cnt;
    logic [7:0]   bo_cnt;
    logic [3:0]   cnt;
    logic [1:0]   idx;
    logic         rw;
    logic [7:0]   sh;
    logic [7:0]   raddr;
    logic         mack;
    logic [6:0]   wiper;
    logic         power_down_ctl_n;
    logic         sda_oe;
  } iwps_dev_t;

  iwps_dev_t r;
  iwps_dev_t n;
  logic      rise;
  logic      fall;
  logic      start;
  logic      stop;
  logic [7:0] rd;

  // Register read decode; unmapped register addresses read as zero
  function automatic logic [7:0] reg_rd(input logic [7:0] a, input logic [6:0] w, input logic s);
    logic [7:0] v;
    v = 8'h00;
    if (a == REG_WIPER) begin
      v = {1'b0, w};
    end else if (a == REG_ACR) begin
      v[POWER_DOWN_CTL_BIT] = s;
    end
    return v;
  endfunction

  // Bus events from the second synchroniser stage and its delayed copy
  assign rise  = r.scl_s & !r.scl_p;
  assign fall  = !r.scl_s & r.scl_p;
  assign start = r.scl_s & r.scl_p & !r.sda_s & r.sda_p;
  assign stop  = r.scl_s & r.scl_p & r.sda_s & !r.sda_p;
  assign rd    = reg_rd(r.raddr, r.wiper, r.power_down_ctl_n);

  // Next-state logic for the whole device
  always_comb begin
    n = r;
    n.scl_m   = bus.scl;
    n.scl_s   = r.scl_m;
    n.scl_p   = r.scl_s;
    n.sda_m   = bus.sda;
    n.sda_s   = r.sda_m;
    n.sda_p   = r.sda_s;
    n.strap_m = {address_strap_upper, address_strap_lower};
    n.strap_s = r.strap_m;
    n.bo_m    = brownout;
    n.bo_s    = r.bo_m;

    // Brownout only matters in shutdown; short dips are filtered out
    if (!r.power_down_ctl_n && r.bo_s) begin
      if (r.bo_cnt >= BO_CYC - 8'h01) begin
        n.wiper  = WIPER_RST;
        n.bo_cnt = 8'h00;
      end else begin
        n.bo_cnt = r.bo_cnt + 8'h01;
      end
    end else begin
      n.bo_cnt = 8'h00;
    end

    if (r.pu_cnt != 8'h00) begin
      // Power-up window: pin stays an input and bus events are dropped
      n.pu_cnt = r.pu_cnt - 8'h01;
      n.st     = D_IDLE;
      n.sda_oe = 1'b0;
    end else if (start) begin
      // A START, repeated or not, always restarts the identity byte
      n.st     = D_RX;
      n.cnt    = 4'h0;
      n.idx    = 2'h0;
      n.sda_oe = 1'b0;
    end else if (stop) begin
      n.st     = D_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      case (r.st)
        D_RX: begin
          if (rise && r.cnt < BYTE_BITS) begin
            n.sh  = {r.sh[6:0], r.sda_s};
            n.cnt = r.cnt + 4'h1;
          end
          if (fall && r.cnt == BYTE_BITS) begin
            n.st     = D_ACK;
            n.sda_oe = 1'b1;
            if (r.idx == 2'h0) begin
              n.rw = r.sh[0];
              if (r.sh[7:1] != {ID_FIXED, r.strap_s}) begin
                // Foreign address: stay off the bus until the next START
                n.st     = D_IDLE;
                n.sda_oe = 1'b0;
              end
            end else if (r.idx == 2'h1) begin
              n.raddr = r.sh;
            end
          end
        end
        D_ACK: begin
          // Data byte of a write lands on the ninth clock
          if (rise && r.idx == 2'h2 && !r.rw) begin
            if (r.raddr == REG_WIPER) begin
              n.wiper = r.sh[6:0];
            end else if (r.raddr == REG_ACR) begin
              n.power_down_ctl_n = r.sh[POWER_DOWN_CTL_BIT];
            end
          end
          if (fall) begin
            n.cnt = 4'h0;
            if (r.rw) begin
              n.st     = D_TX;
              n.sh     = rd;
              n.sda_oe = !rd[7];
            end else begin
              n.st     = D_RX;
              n.sda_oe = 1'b0;
              // Further data bytes of a write keep landing in the same register
              n.idx    = (r.idx == 2'h2) ? 2'h2 : r.idx + 2'h1;
            end
          end
        end
        D_TX: begin
          if (fall) begin
            if (r.cnt == LAST_TX) begin
              n.st     = D_MACK;
              n.sda_oe = 1'b0;
            end else begin
              n.cnt    = r.cnt + 4'h1;
              n.sh     = {r.sh[6:0], 1'b0};
              n.sda_oe = !r.sh[6];
            end
          end
        end
        D_MACK: begin
          if (rise) begin
            n.mack = !r.sda_s;
          end
          if (fall) begin
            if (r.mack) begin
              n.st     = D_TX;
              n.cnt    = 4'h0;
              n.sh     = rd;
              n.sda_oe = !rd[7];
            end else begin
              n.st = D_IDLE;
            end
          end
        end
        default: begin
          n.st     = D_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // State register; wiper and control bit take their power-up values here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r        <= '0;
      r.st     <= D_IDLE;
      r.scl_m  <= 1'b1;
      r.scl_s  <= 1'b1;
      r.scl_p  <= 1'b1;
      r.sda_m  <= 1'b1;
      r.sda_s  <= 1'b1;
      r.sda_p  <= 1'b1;
      r.pu_cnt <= PWRUP_CYC;
      r.wiper  <= WIPER_RST;
      r.power_down_ctl_n <= POWER_DOWN_CTL_RST;
    end else begin
      r <= n;
    end
  end

  // The stored code stays valid through shutdown; the analog side
  // opens the array while power_down_ctl is low
  assign wiper_pos      = r.wiper;
  assign power_down_ctl = r.power_down_ctl_n;
  assign bus.dev_sda_oe = r.sda_oe;
  assign bus.dev_sda_o  = 1'b0;  // Open drain: only ever pulls low

endmodule

// ===== verilog/iwps_host.sv
// Host controller: APB registers driving write and read sequences on the two-wire bus
module iwps_host
  import iwps_pkg::*;
(
  iwps_if.host         bus,
  input  logic         pclk,
  input  logic         presetn,
  input  logic         psel,
  input  logic         penable,
  input  logic         pwrite,
  input  logic [7:0]   paddr,
  input  logic [31:0]  pwdata,
  output logic [31:0]  prdata,
  output logic         pready,
  output logic         pslverr
);
  import iwps_pkg::*;

  typedef struct packed {
    iwps_hstate_t hst;
    logic [1:0]   ph;
    logic [7:0]   qcnt;
    logic [2:0]   step;
    logic [3:0]   bitn;
    logic [7:0]   sh;
    logic         ack_hi;
    logic [1:0]   rxn;
    logic [1:0]   len;
    logic         rd;
    logic [1:0]   strap;
    logic [7:0]   raddr;
    logic [7:0]   wdata;
    logic [31:0]  rdata;
    logic         busy;
    logic         nack;
    logic         scl;
    logic         sda_oe;
    logic         sda_m;
    logic         sda_s;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
  } iwps_host_t;

  iwps_host_t r;
  iwps_host_t n;
  logic       tick;
  logic       last;

  // Byte sent at each transmit step, MSB first
  function automatic logic [7:0] tx_byte(input logic [2:0] s, input iwps_host_t q);
    logic [7:0] v;
    v = 8'hFF;
    case (s)
      STEP_IDW:  v = {ID_FIXED, q.strap, 1'b0};
      STEP_REG:  v = q.raddr;
      STEP_DATA: v = q.wdata;
      STEP_IDR:  v = {ID_FIXED, q.strap, 1'b1};
      default:   v = 8'hFF;
    endcase
    return v;
  endfunction

  assign tick = (r.qcnt == SCL_Q_CYC - 8'h01);
  assign last = (r.rxn == r.len);

  always_comb begin
    n = r;
    n.sda_m = bus.sda;
    n.sda_s = r.sda_m;

    // APB slave: answer is ready in the first access cycle
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    if (psel && !penable) begin
      n.pready = 1'b1;
      n.prdata = 32'h0;
      case (paddr)
        HR_CTRL:   n.prdata = {28'h0, r.len, r.rd, 1'b0};
        HR_TARGET: n.prdata = {16'h0, r.raddr, 6'h0, r.strap};
        HR_WDATA:  n.prdata = {24'h0, r.wdata};
        HR_STATUS: n.prdata = {30'h0, r.nack, r.busy};
        HR_RDATA:  n.prdata = r.rdata;
        default:   n.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && r.pready && pwrite) begin
      case (paddr)
        HR_CTRL: begin
          // A go while busy is dropped; the sequence in flight must finish
          if (pwdata[CTRL_GO] && !r.busy) begin
            n.busy = 1'b1;
            n.nack = 1'b0;
            n.rd   = pwdata[CTRL_READ];
            n.len  = pwdata[CTRL_LEN +: 2];
            n.hst  = H_START;
            n.ph   = 2'h0;
            n.qcnt = 8'h00;
            n.step = STEP_IDW;
            n.rxn  = 2'h0;
          end
        end
        HR_TARGET: begin
          n.strap = pwdata[1:0];
          n.raddr = pwdata[TGT_RADDR +: 8];
        end
        HR_WDATA: n.wdata = pwdata[7:0];
        default: n.wdata = r.wdata;
      endcase
    end

    // Bus engine: every symbol takes four quarter periods
    if (r.hst != H_IDLE) begin
      n.qcnt = tick ? 8'h00 : r.qcnt + 8'h01;
    end
    if (tick) begin
      n.ph = r.ph + 2'h1;
      case (r.hst)
        H_START: begin
          // Also serves as repeated START: data up, clock up, data down, clock down
          case (r.ph)
            2'h0: n.sda_oe = 1'b0;
            2'h1: n.scl = 1'b1;
            2'h2: n.sda_oe = 1'b1;
            default: begin
              n.scl  = 1'b0;
              n.hst  = H_BIT;
              n.bitn = 4'h0;
              n.sh   = tx_byte(r.step, r);
            end
          endcase
        end
        H_BIT: begin
          case (r.ph)
            2'h0: begin
              // Data is set while the clock is low; ninth bit acks all but the last read byte
              if (r.step == STEP_RX) begin
                n.sda_oe = (r.bitn == BYTE_BITS) && !last;
              end else begin
                n.sda_oe = (r.bitn != BYTE_BITS) && !r.sh[7];
              end
            end
            2'h1: n.scl = 1'b1;
            2'h2: begin
              if (r.bitn != BYTE_BITS) begin
                n.sh = {r.sh[6:0], r.sda_s};
              end else begin
                n.ack_hi = r.sda_s;
              end
            end
            default: begin
              n.scl  = 1'b0;
              n.bitn = r.bitn + 4'h1;
              if (r.bitn == BYTE_BITS) begin
                n.bitn = 4'h0;
                if (r.step == STEP_RX) begin
                  n.rdata[{r.rxn, 3'h0} +: 8] = r.sh;
                  n.rxn = r.rxn + 2'h1;
                  if (last) begin
                    n.hst = H_STOP;
                  end
                end else if (r.ack_hi) begin
                  n.nack = 1'b1;
                  n.hst  = H_STOP;
                end else if (r.step == STEP_REG && r.rd) begin
                  n.step = STEP_IDR;
                  n.hst  = H_START;
                end else if (r.step == STEP_DATA) begin
                  n.hst = H_STOP;
                end else begin
                  n.step = r.step + 3'h1;
                  n.sh   = tx_byte(r.step + 3'h1, r);
                end
              end
            end
          endcase
        end
        H_STOP: begin
          case (r.ph)
            2'h0: n.sda_oe = 1'b1;
            2'h1: n.scl = 1'b1;
            2'h2: n.sda_oe = 1'b0;
            default: begin
              n.hst  = H_IDLE;
              n.busy = 1'b0;
            end
          endcase
        end
        default: n.ph = 2'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r       <= '0;
      r.hst   <= H_IDLE;
      r.scl   <= 1'b1;
      r.sda_m <= 1'b1;
      r.sda_s <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign prdata          = r.prdata;
  assign pready          = r.pready;
  assign pslverr         = r.pslverr;
  assign bus.scl         = r.scl;
  assign bus.host_sda_oe = r.sda_oe;
  assign bus.host_sda_o  = 1'b0;

endmodule

// ===== tb/iwps_sva.sv
// Concurrent checks on the two-wire link between host and wiper device
module iwps_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic seen_start_r;

  // Remembers the first START, so any earlier drive by the device shows up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_start_r <= 1'b0;
    end else if (scl && $fell(sda)) begin
      seen_start_r <= 1'b1;
    end
  end

  a_dev_quiet_reset: assert property ($rose(presetn) |-> !dev_sda_oe [*8])
    else $error("device drives data right after reset");
  a_dev_moves_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device moved data while clock high");
  a_clk_phase_held: assert property ($changed(scl) |=> $stable(scl) [*8])
    else $error("bus clock phase too short");
  a_ack_held_high: assert property ($rose(scl) && dev_sda_oe |-> dev_sda_oe [*8])
    else $error("device let go of data during high clock");
  a_quiet_before_start: assert property (!seen_start_r |-> !dev_sda_oe)
    else $error("device drove data before any start");
  a_no_joint_pull: assert property (scl |-> !(dev_sda_oe && host_sda_oe))
    else $error("both ends pull data while clock high");
  a_start_hold: assert property (scl && $fell(sda) |-> scl [*8])
    else $error("start not held with clock high");
  a_stop_standby: assert property (scl && $rose(sda) |-> !dev_sda_oe [*8])
    else $error("device active after stop");

  // Main link events
  c_start: cover property (scl && $fell(sda));
  c_dev_ack: cover property ($rose(scl) && dev_sda_oe);
  c_stop: cover property (scl && $rose(sda));
endmodule

// ===== tb/i2c_wiper_position_slave_tb_top.sv
// Self-checking bench: APB host controller driving the wiper device over the link
module i2c_wiper_position_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import iwps_pkg::*;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        brownout;
  logic [1:0]  straps;
  logic [6:0]  wiper_pos;
  logic        power_down_ctl;
  logic [27:0] cap_r;
  logic        scl_q;
  logic        sda_q;
  logic [31:0] r;
  logic        e;
  int          n_errors;
  int          n_checks;

  iwps_if link ();
  iwps_host i_iwps_host (.bus(link), .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Straps come from the bench so the address match can be moved mid-run
  iwps_device i_iwps_device (.bus(link), .pclk(pclk), .presetn(presetn), .address_strap_upper(straps[1]),
    .address_strap_lower(straps[0]), .brownout(brownout), .wiper_pos(wiper_pos),
    .power_down_ctl(power_down_ctl));
  iwps_sva i_iwps_sva (.pclk(pclk), .presetn(presetn), .scl(link.scl), .sda(link.sda),
    .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe));

  // Free-running 100 MHz clock
  always #5 pclk = ~pclk;

  // Bit capture on clock rise; a START clears it so each frame is seen alone
  always @(posedge pclk) begin
    scl_q <= link.scl;
    sda_q <= link.sda;
    if (link.scl && !scl_q) begin
      cap_r <= {cap_r[26:0], link.sda};
    end else if (link.scl && scl_q && sda_q && !link.sda) begin
      cap_r <= 28'h0;
    end
  end

  task automatic print_verdict();
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 16) begin
      n_errors++;
      print_verdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Start one link sequence and poll until the host is idle again
  task automatic run_op(input logic rd, input logic [1:0] len, input logic [1:0] strap,
                        input logic [7:0] raddr, input logic [7:0] wd);
    int k;
    apb(1'b1, HR_TARGET, {16'h0000, raddr, 6'h00, strap});
    apb(1'b1, HR_WDATA, {24'h000000, wd});
    apb(1'b1, HR_CTRL, {28'h0000000, len, rd, 1'b1});
    for (k = 0; k < 20000; k++) begin
      apb(1'b0, HR_STATUS, 32'h0);
      if (r[ST_BUSY] === 1'b0) break;
    end
    if (k == 20000) begin
      n_errors++;
      print_verdict();
    end
  endtask

  // Brownout pulse longer than the minimum dip, then settle
  task automatic dip();
    brownout <= 1'b1;
    repeat (30) @(posedge pclk);
    brownout <= 1'b0;
    repeat (10) @(posedge pclk);
  endtask

  // Main sequence
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; brownout = 1'b0;
    straps = 2'h1;
    cap_r = 28'h0; scl_q = 1'b1; sda_q = 1'b1; n_errors = 0; n_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    check("idle link", {30'h0, link.scl, link.sda}, 32'h3);
    check("wiper reset", {25'h0, wiper_pos}, 32'h40);
    check("normal reset", {31'h0, power_down_ctl}, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped error", {31'h0, e}, 32'h1);
    // Dip outside shutdown must not move the wiper
    dip();
    check("dip when normal", {25'h0, wiper_pos}, 32'h40);
    // Read of the reset value, then full-scale write
    run_op(1'b1, 2'h0, 2'h1, REG_WIPER, 8'h00);
    check("read frame", {4'h0, cap_r}, {12'h000, 8'hA3, 1'b0, 8'h40, 1'b1, 1'b0});
    apb(1'b0, HR_RDATA, 32'h0);
    check("read wiper", {24'h0, r[7:0]}, 32'h40);
    run_op(1'b0, 2'h0, 2'h1, REG_WIPER, 8'h7F);
    check("write frame", {4'h0, cap_r}, {4'h0, 8'hA2, 1'b0, 8'h00, 1'b0, 8'h7F, 1'b0, 1'b0});
    check("wiper full", {25'h0, wiper_pos}, 32'h7F);
    // Acknowledged read bytes repeat the register
    run_op(1'b1, 2'h2, 2'h1, REG_WIPER, 8'h00);
    apb(1'b0, HR_RDATA, 32'h0);
    check("repeat read", {8'h0, r[23:0]}, 32'h7F7F7F);
    // Shutdown with every other control bit set
    run_op(1'b0, 2'h0, 2'h1, REG_ACR, 8'hBF);
    check("shutdown", {31'h0, power_down_ctl}, 32'h0);
    check("wiper kept", {25'h0, wiper_pos}, 32'h7F);
    run_op(1'b1, 2'h0, 2'h1, REG_ACR, 8'h00);
    apb(1'b0, HR_RDATA, 32'h0);
    check("control read", {24'h0, r[7:0]}, 32'h00);
    // Dip inside shutdown returns the wiper to mid-scale
    dip();
    check("dip in shutdown", {25'h0, wiper_pos}, 32'h40);
    run_op(1'b0, 2'h0, 2'h1, REG_ACR, 8'h40);
    check("normal again", {31'h0, power_down_ctl}, 32'h1);
    check("wiper after exit", {25'h0, wiper_pos}, 32'h40);
    // Wrong strap value is refused
    run_op(1'b0, 2'h0, 2'h2, REG_WIPER, 8'h11);
    apb(1'b0, HR_STATUS, 32'h0);
    check("strap refused", {31'h0, r[ST_NACK]}, 32'h1);
    check("wiper untouched", {25'h0, wiper_pos}, 32'h40);
    // Moved straps: upper strap now set, so the old refused address is accepted
    straps <= 2'h2;
    run_op(1'b0, 2'h0, 2'h2, REG_WIPER, 8'h11);
    apb(1'b0, HR_STATUS, 32'h0);
    check("strap moved ack", {31'h0, r[ST_NACK]}, 32'h0);
    check("strap moved wiper", {25'h0, wiper_pos}, 32'h11);
    print_verdict();
  end
endmodule
